/* File: mpw_unit.sv */
// Purpose: prescaled 32-bit counter with seven match units driving six modulated outputs
// Assumes: all control inputs come from logic on i_clock, so none is synchronised
// Notes: shadow match values load at a cycle match only after release while modulating
`timescale 1ns/10ps

// Behaviour
// - prescaled 32-bit counter of clock cycles
// - seven match registers compared against counter
// - cycle match clears counter, sets period
// - single-edge outputs rise at cycle match
// - single-edge fall at own match value
// - double-edge uses two matches, period from cycle
// - edge order gives positive or negative pulse
// - double-edge edges at any count position
// - six single, up to five double (outputs 2 to 6), or mixed
// - match actions: continue, stop, reset, flag
// - any counts allowed, one shared period
// - released values apply only at cycle start
// - without modulation mode acts as timer
// - all match flags merged into one request
module mpw_unit #(
	parameter int COUNT_W = mpw_pkg::COUNT_W
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// counter control
	input wire logic i_counter_enable,
	input wire logic i_counter_reset,
	input wire logic i_pwm_mode,
	input wire logic [COUNT_W-1:0] i_prescale,
	// match configuration
	input wire logic [mpw_pkg::MATCH_N-1:0][COUNT_W-1:0] i_match_value,
	input wire logic [mpw_pkg::MATCH_N-1:0] i_match_release,
	input wire logic [mpw_pkg::MATCH_N-1:0] i_match_intr,
	input wire logic [mpw_pkg::MATCH_N-1:0] i_match_reset,
	input wire logic [mpw_pkg::MATCH_N-1:0] i_match_stop,
	input wire logic [mpw_pkg::MATCH_N-1:0] i_flag_clear,
	// output configuration, bit 0 stands for output 1
	input wire logic [mpw_pkg::OUT_N-1:0] i_out_enable,
	input wire logic [mpw_pkg::OUT_N-1:0] i_double_edge,
	// status
	output logic [COUNT_W-1:0] o_count,
	output logic [COUNT_W-1:0] o_prescale_count,
	output logic o_running,
	output logic [mpw_pkg::MATCH_N-1:0] o_match_flag,
	output logic [mpw_pkg::MATCH_N-1:0] o_release_pending,
	output logic o_irq,
	// modulated pins, bit 0 stands for output 1
	output logic [mpw_pkg::OUT_N-1:0] o_pwm
);

	logic stopped;
	logic tick;
	logic cycle_wrap;
	logic any_reset;
	logic any_stop;
	logic [mpw_pkg::MATCH_N-1:0] hit;
	logic [mpw_pkg::MATCH_N-1:0][COUNT_W-1:0] shadow;
	logic [mpw_pkg::MATCH_N-1:0][COUNT_W-1:0] effective;
	logic [mpw_pkg::MATCH_N-1:0] next_flag;
	logic [mpw_pkg::OUT_N-1:0] next_pwm;

	// counting stops on a stop match and resumes only after enable is dropped and raised
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stopped <= 1'b0;
		end else if (!i_counter_enable) begin
			stopped <= 1'b0;
		end else if (any_stop) begin
			stopped <= 1'b1;
		end
	end

	assign tick = i_counter_enable && !stopped && !i_counter_reset
		&& (o_prescale_count == i_prescale);

	// prescaler restarts on reaching its value
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_prescale_count <= COUNT_W'(mpw_pkg::COUNT_RESET);
		end else if (i_counter_reset || tick) begin
			o_prescale_count <= COUNT_W'(mpw_pkg::COUNT_RESET);
		end else if (i_counter_enable && !stopped) begin
			o_prescale_count <= o_prescale_count + COUNT_W'(mpw_pkg::COUNT_STEP);
		end
	end

	// timer mode compares live values; modulation compares only released shadows
	always_comb begin
		for (int m = 0; m < mpw_pkg::MATCH_N; m++) begin
			effective[m] = i_pwm_mode ? shadow[m] : i_match_value[m];
			hit[m] = tick && (o_count == effective[m]);
		end
	end

	// the cycle match always closes the period while modulating
	assign cycle_wrap = hit[mpw_pkg::CYCLE_IDX]
		&& (i_pwm_mode || i_match_reset[mpw_pkg::CYCLE_IDX]);
	assign any_reset = cycle_wrap || |(hit & i_match_reset);
	assign any_stop = |(hit & i_match_stop);

	// counter: a reset match wins over the increment so the count never overshoots
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_count <= COUNT_W'(mpw_pkg::COUNT_RESET);
		end else if (i_counter_reset) begin
			o_count <= COUNT_W'(mpw_pkg::COUNT_RESET);
		end else if (any_reset) begin
			o_count <= COUNT_W'(mpw_pkg::COUNT_RESET);
		end else if (tick && !any_stop) begin
			o_count <= o_count + COUNT_W'(mpw_pkg::COUNT_STEP);
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_running <= 1'b0;
		end else begin
			o_running <= i_counter_enable && !stopped && !any_stop && !i_counter_reset;
		end
	end

	// shadow loading: while modulating only at the cycle wrap, so a half-updated pair never shapes a pulse
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			shadow <= '0;
			o_release_pending <= mpw_pkg::FLAG_RESET;
		end else begin
			for (int m = 0; m < mpw_pkg::MATCH_N; m++) begin
				if (!i_pwm_mode) begin
					shadow[m] <= i_match_value[m];
					o_release_pending[m] <= 1'b0;
				end else if (cycle_wrap && (o_release_pending[m] || i_match_release[m])) begin
					shadow[m] <= i_match_value[m];
					o_release_pending[m] <= 1'b0;
				end else if (i_match_release[m]) begin
					o_release_pending[m] <= 1'b1;
				end
			end
		end
	end

	// sticky flags: a hit in the cycle of its clear is kept
	always_comb begin
		for (int m = 0; m < mpw_pkg::MATCH_N; m++) begin
			next_flag[m] = (hit[m] && i_match_intr[m])
				|| (o_match_flag[m] && !i_flag_clear[m]);
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_match_flag <= mpw_pkg::FLAG_RESET;
			o_irq <= 1'b0;
		end else begin
			o_match_flag <= next_flag;
			o_irq <= |next_flag;
		end
	end

	// output edges; reset beats set, so a fall matching the rise keeps the pin low
	always_comb begin
		for (int n = 1; n <= mpw_pkg::OUT_N; n++) begin
			logic set_edge;
			logic clr_edge;
			set_edge = 1'b0;
			clr_edge = hit[n];
			if (i_double_edge[n-1] && n > 1) begin
				set_edge = hit[n-1];
			end else begin
				set_edge = cycle_wrap;
			end
			if (!i_pwm_mode || !i_out_enable[n-1]) begin
				next_pwm[n-1] = 1'b0;
			end else if (clr_edge) begin
				next_pwm[n-1] = 1'b0;
			end else if (set_edge) begin
				next_pwm[n-1] = 1'b1;
			end else begin
				next_pwm[n-1] = o_pwm[n-1];
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pwm <= mpw_pkg::PWM_RESET;
		end else begin
			o_pwm <= next_pwm;
		end
	end

endmodule : mpw_unit

/* File: mpw_pkg.sv */
// Purpose: shared constants for the match based pulse width modulator
// Assumes: one clock domain, control bits arrive as plain ports
// Notes: counts and reset values live here so the core holds no bare numbers
package mpw_pkg;
	localparam int COUNT_W = 32;
	localparam int MATCH_N = 7;
	localparam int OUT_N = 6;
	localparam int CYCLE_IDX = 0;
	localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
	localparam logic [31:0] COUNT_STEP = 32'h0000_0001;
	localparam logic [31:0] MATCH_RESET = 32'h0000_0000;
	localparam logic [6:0] FLAG_RESET = 7'h00;
	localparam logic [5:0] PWM_RESET = 6'h00;
endpackage : mpw_pkg

/* File: mpw_unit_properties.sv */
// Purpose: port checks for mpw_unit
// Assumes: one clock, async low reset
// Notes: bound after endmodule
`timescale 1ns/10ps
module mpw_props (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_counter_enable,
	input wire logic i_counter_reset,
	input wire logic i_pwm_mode,
	input wire logic [5:0] i_out_enable,
	input wire logic [6:0] i_flag_clear,
	input wire logic [31:0] o_count,
	input wire logic [6:0] o_match_flag,
	input wire logic o_irq,
	input wire logic [5:0] o_pwm
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	a_rst_zero: assert property (i_counter_reset |=> o_count == '0) else $error("rst");
	a_cnt_step: assert property (!$stable(o_count) |->
		o_count == '0 || o_count == $past(o_count) + 1) else $error("step");
	a_cnt_hold: assert property (!i_counter_enable && !i_counter_reset
		|=> $stable(o_count)) else $error("hold");
	a_timer_low: assert property (!i_pwm_mode |=> o_pwm == '0) else $error("pwm");
	a_irq_merge: assert property (o_irq == (|o_match_flag)) else $error("irq");
	a_flag_keep: assert property (o_match_flag[0] && !i_flag_clear[0]
		|=> o_match_flag[0]) else $error("flag");
	a_out_off: assert property (!i_out_enable[5] |=> !o_pwm[5]) else $error("off");
	a_rise_wrap: assert property ($rose(o_pwm[0]) |-> o_count == '0) else $error("rise");
	cover property ($rose(o_pwm[2]));
	cover property ($rose(o_irq));
	cover property (!i_pwm_mode && $stable(o_count));
endmodule : mpw_props
bind mpw_unit mpw_props PROPS (.i_clock, .i_rst_n, .i_counter_enable, .i_counter_reset,
	.i_pwm_mode, .i_out_enable, .i_flag_clear, .o_count, .o_match_flag, .o_irq, .o_pwm);

/* File: mpw_load.sv */
// Purpose: load model on the modulated pins
// Assumes: pins sampled on rising edges
// Notes: counts high cycles per pin
`timescale 1ns/10ps
module mpw_load (
	input wire logic i_clock,
	input wire logic i_clear,
	input wire logic [5:0] i_pin,
	output logic [5:0][15:0] o_high
);
	always_ff @(posedge i_clock)
		for (int k = 0; k < 6; k++)
			o_high[k] <= i_clear ? 16'h0 : o_high[k] + 16'(i_pin[k]);
endmodule : mpw_load

/* File: tb.sv */
// Purpose: directed bench for mpw_unit
// Assumes: inputs move on falling edges
// Notes: windows span whole periods, so phase never matters
`timescale 1ns/10ps
module tb;
	logic i_clock = 0, rst_n = 0, en = 0, crst = 0, pm = 1, clr = 0, run, irq;
	logic [31:0] pre = 32'h0, cnt;
	logic [6:0][31:0] mv = {32'h2, 32'h9, 32'h0, 32'h5, 32'h7, 32'h3, 32'h9};
	logic [6:0] rel = 7'h0, stp = 7'h0, fc = 7'h0, flg;
	logic [6:0] mrst = 7'h0, mie = 7'h7f, pnd;
	logic [31:0] ps;
	logic [5:0] pwm;
	logic [5:0][15:0] hi;
	int n_mismatch = 0, n_checks = 0;
	always #2 i_clock = ~i_clock;
	mpw_unit DUT (.i_clock, .i_rst_n(rst_n), .i_counter_enable(en), .i_counter_reset(crst),
		.i_pwm_mode(pm), .i_prescale(pre), .i_match_value(mv), .i_match_release(rel),
		.i_match_intr(mie), .i_match_reset(mrst), .i_match_stop(stp), .i_flag_clear(fc),
		.i_out_enable(6'h1f), .i_double_edge(6'h06), .o_count(cnt), .o_prescale_count(ps),
		.o_running(run), .o_match_flag(flg), .o_release_pending(pnd), .o_irq(irq), .o_pwm(pwm));
	mpw_load LOAD (.i_clock, .i_clear(clr), .i_pin(pwm), .o_high(hi));
	task cyc(input int n);
		repeat (n) @(negedge i_clock);
	endtask : cyc
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %0t %h %h", $time, g, e);
		end
	endtask : chk
	task conclude;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude
	task duty(input int n, input logic [5:0][15:0] e);
		clr = 1;
		cyc(1);
		clr = 0;
		cyc(n);
		for (int k = 0; k < 6; k++)
			chk(32'(hi[k]), 32'(e[k]));
	endtask : duty
	initial begin
		cyc(8);
		rst_n = 1;
		cyc(2);
		en = 1;
		rel = 7'h7f;
		cyc(1);
		rel = 7'h0;
		cyc(30);
		duty(50, {16'h0, 16'h0, 16'h5, 16'h28, 16'h14, 16'h14});
		mv[1] = 32'h6;
		duty(50, {16'h0, 16'h0, 16'h5, 16'h28, 16'h14, 16'h14});
		rel = 7'h02;
		cyc(1);
		chk(32'(pnd), 32'h02);
		rel = 7'h0;
		cyc(12);
		chk(32'(pnd), 32'h0);
		duty(50, {16'h0, 16'h0, 16'h5, 16'h28, 16'h5, 16'h23});
		pre = 32'h1;
		cyc(40);
		duty(100, {16'h0, 16'h0, 16'ha, 16'h50, 16'ha, 16'h46});
		// stop at match 2; flags and counter are cleared first so hits start clean
		pre = 32'h0;
		pm = 0;
		stp = 7'h04;
		crst = 1;
		fc = 7'h7f;
		cyc(1);
		crst = 0;
		fc = 7'h0;
		cyc(11);
		chk(32'(pwm), 32'h0);
		chk(cnt, 32'h7);
		chk(32'(run), 32'h0);
		chk(32'(flg), 32'h5e);
		chk(32'(irq), 32'h1);
		fc = 7'h7f;
		cyc(1);
		fc = 7'h0;
		cyc(1);
		chk(32'(irq), 32'h0);
		// timer mode reset action on match 6, flag only where enabled, prescale of 2
		en = 0;
		crst = 1;
		fc = 7'h7f;
		stp = 7'h0;
		mrst = 7'h40;
		mie = 7'h40;
		pre = 32'h2;
		cyc(1);
		en = 1;
		crst = 0;
		fc = 7'h0;
		cyc(10);
		chk(cnt, 32'h0);
		chk(ps, 32'h1);
		chk(32'(flg), 32'h40);
		chk(32'(run), 32'h1);
		conclude();
	end
endmodule : tb
